// [hw/iss_pkg.sv]
// Constants and types shared by the instruction sequencer block.
package iss_pkg;

  // Program counter and stack geometry.
  localparam int PcWidth = 13;
  localparam int StackDepth = 8;
  localparam int StackPtrWidth = 3;
  localparam logic [3:0] DepthEmpty = 4'h0;
  localparam logic [3:0] DepthFull = 4'h8;

  // Register byte offsets on the APB slave.
  localparam logic [11:0] OffPcLow = 12'h000;
  localparam logic [11:0] OffStatus = 12'h004;
  localparam logic [11:0] OffControl = 12'h008;
  localparam logic [11:0] OffAccum = 12'h00C;

  // Status flag positions.
  localparam int FlagC = 0;
  localparam int FlagAc = 1;
  localparam int FlagZ = 2;
  localparam int FlagOv = 3;

  // Control register field position.
  localparam int CtrlBank = 0;

  // Reset values and the default interrupt vector.
  localparam logic [3:0] PhaseReset = 4'h1;
  localparam logic [12:0] PcReset = 13'h0000;
  localparam logic [12:0] IntVectorDefault = 13'h0004;

  // Kind of work the executing instruction asks for.
  typedef enum logic [3:0] {
    KNop, KAlu, KJump, KCall, KSubReturn, KIntReturn, KSkipZ, KSkipNz
  } iss_kind_e;

  // ALU operation select.
  typedef enum logic [3:0] {
    AAdd, AAdc, ASub, ASbc, ADecAdj, AAnd, AOr, AXor,
    ACpl, ARr, ARrc, ARl, ARlc, AInc, ADec, AMov
  } iss_alu_e;

  // Decoded instruction word delivered by the fetch path.
  typedef struct packed {
    iss_kind_e kind;
    logic ext;
    iss_alu_e aluOp;
    logic toMem;
    logic [12:0] target;
    logic [7:0] operand;
  } iss_instr_s;

  // Result write toward the data memory bus.
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } iss_wr_s;

  // Whole state of the sequencer.
  typedef struct packed {
    logic [3:0] phase;
    logic [12:0] pc;
    logic bank;
    iss_instr_s fetched;
    logic [12:0] fetchedAddr;
    logic fetchedValid;
    iss_instr_s exec;
    logic [12:0] execAddr;
    logic execValid;
    logic extSecond;
    logic [7:0] acc;
    logic [3:0] flags;
    logic [StackDepth-1:0][12:0] stack;
    logic [StackPtrWidth-1:0] top;
    logic [3:0] depth;
    logic pclPend;
    logic [7:0] pclVal;
    logic intAck;
    iss_wr_s dataWr;
  } iss_state_s;

endpackage

// [hw/iss_sequencer.sv]
// Instruction sequencer with phase clocks, program counter, stack and ALU.
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/1ns
module iss_sequencer #(
  parameter logic [12:0] IntVector = iss_pkg::IntVectorDefault
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [13:0] fetchAddr,
  output logic fetchStrobe,
  input wire iss_pkg::iss_instr_s fetchInstr,
  output iss_pkg::iss_wr_s dataWr,
  input wire logic intReq,
  output logic intAck,
  output logic stackFull,
  output logic [3:0] phaseOneHot
);
  import iss_pkg::*;

  // Every flip-flop lives in one packed struct. The combinational block
  // below builds the next copy and one clocked process registers it, so
  // no field can ever pick up a second driver.
  iss_state_s s;
  iss_state_s n;
  logic apbAccess;
  logic apbMapped;

  // ALU: returns new flags above the 8-bit result.
  function automatic logic [11:0] aluRun(
    input iss_alu_e op,
    input logic [7:0] a,
    input logic [7:0] b,
    input logic [3:0] f
  );
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] addend;
    logic cin;
    logic [7:0] r;
    logic [3:0] nf;
    nf = f;
    r = b;
    addend = b;
    cin = 1'b0;
    sum = 9'h000;
    low = 5'h00;
    // Subtract adds the inverted operand with a carry in, so the carry
    // flag reads one when no borrow occurred.
    case (op)
      AAdd, AAdc, ASub, ASbc: begin
        addend = (op == ASub || op == ASbc) ? ~b : b;
        if (op == AAdc || op == ASbc) begin
          cin = f[FlagC];
        end else begin
          cin = (op == ASub);
        end
        sum = {1'b0, a} + {1'b0, addend} + {8'h00, cin};
        low = {1'b0, a[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
        r = sum[7:0];
        nf[FlagC] = sum[8];
        nf[FlagAc] = low[4];
        nf[FlagOv] = (a[7] == addend[7]) && (r[7] != a[7]);
      end
      ADecAdj: begin
        sum = {1'b0, a};
        if (a[3:0] > 4'h9 || f[FlagAc]) begin
          sum = sum + 9'h006;
        end
        if (sum[8:4] > 5'h09 || f[FlagC]) begin
          sum = sum + 9'h060;
        end
        r = sum[7:0];
        nf[FlagC] = sum[8] | f[FlagC];
      end
      AAnd: r = a & b;
      AOr: r = a | b;
      AXor: r = a ^ b;
      ACpl: r = ~b;
      ARr: r = {b[0], b[7:1]};
      ARrc: begin
        r = {f[FlagC], b[7:1]};
        nf[FlagC] = b[0];
      end
      ARl: r = {b[6:0], b[7]};
      ARlc: begin
        r = {b[6:0], f[FlagC]};
        nf[FlagC] = b[7];
      end
      AInc: r = b + 8'h01;
      ADec: r = b - 8'h01;
      AMov: r = b;
      default: r = b;
    endcase
    // Rotates leave the zero flag alone; everything else refreshes it.
    if (!(op inside {ARr, ARrc, ARl, ARlc})) begin
      nf[FlagZ] = (r == 8'h00);
    end
    return {nf, r};
  endfunction

  // APB decode: zero wait states, unmapped offsets answer with an error.
  // The slave never stalls, so a transfer ends in its first access cycle.
  // Software can reach neither the stack nor its pointer.
  assign apbAccess = psel && penable;
  assign apbMapped = (paddr == OffPcLow) || (paddr == OffStatus) ||
                     (paddr == OffControl) || (paddr == OffAccum);
  assign pready = 1'b1;
  assign pslverr = apbAccess && !apbMapped;

  // Read data mux; the stack and its pointer have no address.
  // low byte only
  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      OffPcLow: prdata[7:0] = s.pc[7:0];
      OffStatus: prdata[3:0] = s.flags;
      OffControl: prdata[CtrlBank] = s.bank;
      OffAccum: prdata[7:0] = s.acc;
      default: prdata = 32'h0000_0000;
    endcase
  end

  // Next state of the whole sequencer.
  // The four phases run as a one-hot ring. Fetch happens on the first
  // phase, and the instruction fetched one cycle earlier completes on
  // the last phase, which is where every redirect is decided.
  // Only one redirect wins per cycle: the executing instruction first,
  // then a queued low byte write, then an interrupt.
  // An interrupt is taken only while a valid prefetched word exists, so
  // the address pushed is always one that has not yet run.
  always_comb begin
    logic [11:0] aluOut;
    logic redirect;
    logic [12:0] tgt;
    logic doPush;
    logic [12:0] pushVal;
    logic doPop;
    logic doWrite;
    logic skipTaken;
    aluOut = 12'h000;
    redirect = 1'b0;
    tgt = s.pc;
    doPush = 1'b0;
    pushVal = s.pc;
    doPop = 1'b0;
    doWrite = 1'b0;
    skipTaken = 1'b0;
    n = s;
    n.intAck = 1'b0;
    n.dataWr.valid = 1'b0;

    n.phase = {s.phase[2:0], s.phase[3]};

    if (s.phase[0] && !s.extSecond) begin
      n.fetched = fetchInstr;
      n.fetchedAddr = s.pc;
      n.fetchedValid = 1'b1;
      n.pc = s.pc + 13'h0001;
    end

    // Execution completes at the end of the last phase.
    if (s.phase[3]) begin
      aluOut = aluRun(s.exec.aluOp, s.acc, s.exec.operand, s.flags);
      if (s.execValid && s.exec.ext && !s.extSecond) begin
        n.extSecond = 1'b1;
      end else begin
        n.extSecond = 1'b0;
        n.exec = s.fetched;
        n.execAddr = s.fetchedAddr;
        n.execValid = s.fetchedValid;
        n.fetchedValid = 1'b0;
        if (s.execValid) begin
          case (s.exec.kind)
            KAlu: doWrite = 1'b1;
            KSkipZ: begin
              doWrite = 1'b1;
              skipTaken = (aluOut[7:0] == 8'h00);
            end
            KSkipNz: begin
              doWrite = 1'b1;
              skipTaken = (aluOut[7:0] != 8'h00);
            end
            KJump: begin
              redirect = 1'b1;
              tgt = s.exec.target;
            end
            KCall: begin
              redirect = 1'b1;
              tgt = s.exec.target;
              doPush = 1'b1;
              pushVal = s.execAddr + 13'h0001;
            end
            KSubReturn, KIntReturn: begin
              redirect = 1'b1;
              tgt = s.stack[s.top];
              doPop = 1'b1;
            end
            default: redirect = 1'b0;
          endcase
        end
        if (doWrite) begin
          n.flags = aluOut[11:8];
          if (s.exec.toMem) begin
            n.dataWr.valid = 1'b1;
            n.dataWr.data = aluOut[7:0];
          end else begin
            n.acc = aluOut[7:0];
          end
        end
        if (skipTaken) begin
          redirect = 1'b1;
          tgt = s.pc;
        end
        if (!redirect && s.pclPend) begin
          redirect = 1'b1;
          tgt = {s.pc[12:8], s.pclVal};
          n.pclPend = 1'b0;
        end else if (!redirect && intReq && s.fetchedValid &&
                     s.depth != DepthFull) begin
          redirect = 1'b1;
          tgt = IntVector;
          doPush = 1'b1;
          pushVal = s.fetchedAddr;
          n.intAck = 1'b1;
        end
        if (redirect) begin
          n.pc = tgt;
          n.execValid = 1'b0;
          n.fetchedValid = 1'b0;
        end
      end
    end

    // The stack is a ring of eight words. A push on a full stack moves
    // the top over the oldest word, which is then lost; the depth count
    // saturates so the full flag stays set. A pop on an empty stack only
    // moves the pointer, so a stray return cannot wrap the depth to full.
    // circular eight-entry stack
    if (doPush) begin
      n.top = s.top + 3'h1;
      n.stack[n.top] = pushVal;
      if (s.depth != DepthFull) begin
        n.depth = s.depth + 4'h1;
      end
    end else if (doPop) begin
      n.top = s.top - 3'h1;
      if (s.depth != DepthEmpty) begin
        n.depth = s.depth - 4'h1;
      end
    end

    // Register writes; a new low byte write wins over the one consumed.
    // A flag write in the same cycle as an ALU result is applied last,
    // so software wins over the hardware update.
    if (apbAccess && pwrite && apbMapped) begin
      case (paddr)
        OffPcLow: begin
          n.pclPend = 1'b1;
          n.pclVal = pwdata[7:0];
        end
        OffStatus: n.flags = pwdata[3:0];
        OffControl: n.bank = pwdata[CtrlBank];
        default: n.bank = s.bank;
      endcase
    end
  end

  // State register.
  // Reset clears the whole struct, then sets the first phase, the reset
  // vector and an empty stack.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.phase <= PhaseReset;
      s.pc <= PcReset;
      s.depth <= DepthEmpty;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from state.
  // The fetch address carries the bank bit above the thirteen-bit counter.
  assign fetchAddr = {s.bank, s.pc};
  assign fetchStrobe = s.phase[0] && !s.extSecond;
  assign dataWr = s.dataWr;
  assign intAck = s.intAck;
  assign stackFull = (s.depth == DepthFull);
  assign phaseOneHot = s.phase;

endmodule

// [testbench/iss_checker.sv]
// Port assertions for the instruction sequencer.
`timescale 1ns/1ns
module iss_checker #(
  parameter logic [12:0] IntVector = iss_pkg::IntVectorDefault
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic [13:0] fetchAddr,
  input wire logic fetchStrobe,
  input wire iss_pkg::iss_wr_s dataWr,
  input wire logic intReq,
  input wire logic intAck,
  input wire logic stackFull,
  input wire logic [3:0] phaseOneHot
);
  import iss_pkg::*;
  // Every check samples on the rising edge and rests during reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_phase_rotate: assert property (phaseOneHot[0] |=> phaseOneHot[1]
    ##1 phaseOneHot[2] ##1 phaseOneHot[3] ##1 phaseOneHot[0])
    else $error("Phases out of order.");
  a_fetch_spacing: assert property (fetchStrobe |-> phaseOneHot[0]
    ##1 !fetchStrobe [*3]) else $error("Fetch spacing wrong.");
  a_reset_vector: assert property ($rose(resetn) |->
    fetchStrobe && fetchAddr == 14'h0000) else $error("No fetch at zero.");
  a_pcl_read: assert property (psel && penable && !pwrite &&
    paddr == OffPcLow |-> prdata == {24'h000000, fetchAddr[7:0]})
    else $error("Low byte read wrong.");
  a_int_gate: assert property (intAck |-> $past(intReq) &&
    !$past(stackFull)) else $error("Blocked interrupt taken.");
  a_int_target: assert property (intAck |-> fetchStrobe &&
    fetchAddr[12:0] == IntVector) else $error("Vector missed.");
  a_write_slot: assert property (dataWr.valid |->
    $past(phaseOneHot[3]) ##1 !dataWr.valid) else $error("Write slot wrong.");
  a_stack_edge: assert property ($changed(stackFull) |->
    $past(phaseOneHot[3])) else $error("Stack moved off phase four.");
  // Main scenarios the bench should reach.
  c_int_taken: cover property (intAck);
  c_stack_full: cover property ($rose(stackFull));
  c_result_write: cover property (dataWr.valid);
endmodule

bind iss_sequencer iss_checker #(.IntVector(IntVector)) chk (.clk, .resetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .fetchAddr, .fetchStrobe,
  .dataWr, .intReq, .intAck, .stackFull, .phaseOneHot);

// [testbench/iss_prog_mem.sv]
// Program memory model that answers fetches and logs result writes.
`timescale 1ns/1ns
module iss_prog_mem (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [13:0] fetchAddr,
  input wire logic fetchStrobe,
  output iss_pkg::iss_instr_s fetchInstr,
  input wire iss_pkg::iss_wr_s dataWr
);
  import iss_pkg::*;
  iss_instr_s mem [256];
  logic [13:0] seen [$];
  logic [7:0] lastWr;
  int nWr = 0;
  // Outside a fetch the word is inverted so stale data never passes.
  assign fetchInstr = fetchStrobe ? mem[fetchAddr[7:0]] :
    iss_instr_s'(~mem[fetchAddr[7:0]]);
  // Each taken fetch address and each result write is logged.
  always @(posedge clk) begin
    if (resetn && fetchStrobe) begin
      seen.push_back(fetchAddr);
    end
    if (resetn && dataWr.valid) begin
      lastWr <= dataWr.data;
      nWr <= nWr + 1;
    end
  end
endmodule

// [testbench/instruction_sequencer_stack_bench.sv]
// Self-checking bench for the instruction sequencer.
`timescale 1ns/1ns
module instruction_sequencer_stack_bench;
  import iss_pkg::*;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, intReq = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic pready, pslverr, rerr, fetchStrobe, intAck, stackFull;
  logic [13:0] fetchAddr;
  logic [3:0] phaseOneHot;
  iss_instr_s fetchInstr;
  iss_wr_s dataWr;
  int failures = 0, n_tests = 0;
  logic [13:0] ex [11] = '{14'h0000, 14'h0001, 14'h0002, 14'h0003,
    14'h0004, 14'h0005, 14'h0020, 14'h0021, 14'h0005, 14'h0006, 14'h01A0};

  // Clock at 25 MHz.
  always #20 clk = ~clk;

  iss_sequencer #(.IntVector(13'h0080)) uut (.clk, .resetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .fetchAddr, .fetchStrobe, .fetchInstr, .dataWr, .intReq, .intAck,
    .stackFull, .phaseOneHot);
  iss_prog_mem pm (.clk, .resetn, .fetchAddr, .fetchStrobe, .fetchInstr,
    .dataWr);

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic iss_instr_s mk(iss_kind_e k, iss_alu_e op, logic m,
      logic [12:0] t, logic [7:0] v);
    mk = '{kind: k, ext: 1'b0, aluOp: op, toMem: m, target: t, operand: v};
  endfunction

  function automatic int hits(input logic [13:0] a);
    hits = 0;
    foreach (pm.seen[i]) begin
      if (pm.seen[i] === a) hits = hits + 1;
    end
  endfunction

  // One APB transfer; data and error are taken at the ready edge.
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      end_sim();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits until the model has logged n fetches.
  task automatic fetches(input int n);
    int k;
    k = 0;
    while (pm.seen.size() < n && k < 400) begin
      @(negedge clk);
      k++;
    end
    if (k == 400) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic test_reset();
    repeat (20) @(posedge clk);
    chk(32'(phaseOneHot), 32'h00000001);
    chk(32'(stackFull), 32'h00000000);
    resetn <= 1'b1;
    $display("test_reset done");
  endtask

  // Straight code, taken skip, call, return and jump in the fetch trace.
  task automatic test_flow();
    fetches(11);
    foreach (ex[i]) begin
      chk(32'(pm.seen[i]), 32'(ex[i]));
    end
    apb(1'b0, OffAccum, 32'h00000000);
    chk(rd, 32'h00000000);
    apb(1'b0, OffStatus, 32'h00000000);
    chk(rd & 32'h00000005, 32'h00000005);
    chk(32'(pm.nWr), 32'h00000001);
    chk(32'(pm.lastWr), 32'h00000000);
    $display("test_flow done");
  endtask

  // Unmapped access and the bank bit on the fetch address.
  task automatic test_regs();
    apb(1'b0, 12'h010, 32'h00000000);
    chk({rd[30:0], rerr}, 32'h00000001);
    apb(1'b1, OffControl, 32'h00000001);
    @(negedge clk);
    pm.seen.delete();
    fetches(1);
    chk(32'(pm.seen[0][13]), 32'h00000001);
    apb(1'b1, OffControl, 32'h00000000);
    $display("test_regs done");
  endtask

  // A low byte write jumps inside the current page.
  task automatic test_pcl();
    pm.seen.delete();
    apb(1'b1, OffPcLow, 32'h00000040);
    fetches(3);
    chk(32'(hits(14'h0140) > 0), 32'h00000001);
    $display("test_pcl done");
  endtask

  // Calls fill the stack, a waiting interrupt is served after a return.
  task automatic test_stack();
    int k;
    k = 0;
    while (stackFull !== 1'b1 && k < 400) begin
      @(negedge clk);
      k++;
    end
    chk(32'(stackFull), 32'h00000001);
    @(posedge clk);
    intReq <= 1'b1;
    pm.seen.delete();
    fetches(6);
    chk(32'(hits(14'h0140)), 32'h00000003);
    pm.mem[8'h40] = mk(KSubReturn, AMov, 1'b0, 13'h0000, 8'h00);
    k = 0;
    while (intAck !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk(32'(intAck), 32'h00000001);
    pm.seen.delete();
    @(posedge clk);
    intReq <= 1'b0;
    fetches(3);
    chk(32'(pm.seen[0]), 32'h00000080);
    chk(32'(pm.seen[2]), 32'h00000141);
    chk(32'(stackFull), 32'h00000000);
    $display("test_stack done");
  endtask

  // Program image, then the scenarios in order.
  initial begin
    foreach (pm.mem[i]) begin
      pm.mem[i] = mk(KNop, AAdd, 1'b0, 13'h0000, 8'h00);
    end
    pm.mem[8'h00] = mk(KAlu, AMov, 1'b0, 13'h0000, 8'h5A);
    pm.mem[8'h01] = mk(KAlu, AAdd, 1'b0, 13'h0000, 8'hA6);
    pm.mem[8'h02] = mk(KSkipZ, AMov, 1'b1, 13'h0000, 8'h00);
    pm.mem[8'h04] = mk(KCall, AMov, 1'b0, 13'h0020, 8'h00);
    pm.mem[8'h05] = mk(KJump, AMov, 1'b0, 13'h01A0, 8'h00);
    pm.mem[8'h20] = mk(KSubReturn, AMov, 1'b0, 13'h0000, 8'h00);
    pm.mem[8'h40] = mk(KCall, AMov, 1'b0, 13'h0140, 8'h00);
    pm.mem[8'h80] = mk(KIntReturn, AMov, 1'b0, 13'h0000, 8'h00);
    test_reset();
    test_flow();
    test_regs();
    test_pcl();
    test_stack();
    end_sim();
  end
endmodule
